// File: gble_pkg.sv
// gble_pkg: constants, register map and types of the output logic pin block
// Overview of operation
// - twenty-one two-way pins, each input or output
// - outputs open-drain or push-pull, selectable per pin
// - two extra pins: input or pulse-width only
// - role counts capped per role type
// - pins feed sequencing, alarms and system signals
// - rail enable role drives pin like rail
// - output driven by host or logic engine
// - output logic is OR of two AND terms
// - term inputs: first eight outputs, inputs, statuses
// - one status type per term, rails picked by mask
// - live status types plus latching variants
// - latched flag holds until cleared
// - dependencies use output logic state, not pin
// - power-good in logic only for monitored rails
// - delay on assertion, deassertion, both, neither
// - reverting change within delay is filtered
// - ignore mode commits change, ignores input
// - ignore mode pulses last at least delay
// - state-machine mode evaluates one term only
// - true uses term zero, false term one
// - input polarity active-low or active-high
// - one latch-clear input clears latched flags
`default_nettype none
package gble_pkg;
  localparam int NPIN = 21; // general two-way pins
  localparam int NALL = 23; // plus the two input or pulse-width pins
  localparam int NRAIL = 10;
  localparam int NSLOT = 10; // logic output slots
  localparam int NDEP = 8; // outputs usable inside terms
  localparam int NGPI = 8;
  localparam int MAX_RAIL_EN = 10;
  localparam int MAX_IN = 8;
  localparam int MAX_OUT = 10;
  localparam int MAX_PWM = 10;
  localparam int MAX_MPWM = 10;
  // status types: 0..16 live, 17..30 latching copies of live 3..16
  localparam int NLIVE = 17;
  localparam int NLAT = 14;
  localparam int LAT_FIRST = 3;
  localparam int LAT_CODE = 17;
  localparam int TYPE_W = 5;
  localparam logic [TYPE_W-1:0] TY_PG = 5'h00;
  // delay timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DLY_TICK_NS = 1000000; // delay unit, 1 ms
  localparam int DLY_TICK_CYC = DLY_TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 16;
  localparam int DLY_W = 16;
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PIDX_W = 5;
  localparam logic [ADDR_W-1:0] A_SLOT_BASE = 8'h40; // 4 words per slot
  localparam logic [ADDR_W-1:0] A_STAT = 8'h70; // write: commands
  localparam logic [ADDR_W-1:0] A_LVL = 8'h71;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h72;
  localparam logic [1:0] SUB_CFG = 2'h0;
  localparam logic [1:0] SUB_T0 = 2'h1;
  localparam logic [1:0] SUB_T1 = 2'h2;
  localparam logic [1:0] SUB_DLY = 2'h3;
  // pin configuration word
  localparam int PC_W = 10;
  localparam int PC_ROLE_LSB = 0;
  localparam int ROLE_W = 3;
  localparam int PC_PP = 3;
  localparam int PC_AH = 4;
  localparam int PC_SEL_LSB = 5;
  localparam int SEL_W = 4;
  localparam int PC_LCLR = 9;
  localparam logic [PC_W-1:0] PC_RST = 10'h000; // input, active low
  // slot configuration word
  localparam int SC_W = 6;
  localparam int SC_MAN = 0;
  localparam int SC_MVAL = 1;
  localparam int SC_SM = 2;
  localparam int SC_DA = 3;
  localparam int SC_DD = 4;
  localparam int SC_IGN = 5;
  // term word
  localparam int T_GPO_LSB = 0;
  localparam int T_GPI_LSB = 8;
  localparam int T_TYPE_LSB = 16;
  localparam int T_RAIL_LSB = 21;
  localparam int T_EN = 31;
  // status and command bits
  localparam int ST_REF = 0;
  localparam int ST_LAT = 1;
  localparam int CMD_LCLR = 0;
  localparam int CMD_RCLR = 1;
  localparam int CNT_W = 5;
  typedef enum logic [ROLE_W-1:0] {
    GBLE_ROLE_IN, GBLE_ROLE_OUT, GBLE_ROLE_RAIL_EN, GBLE_ROLE_PWM, GBLE_ROLE_MPWM
  } gble_role_t;
  // pins allowed per role, also the bound of the selector field
  function automatic logic [CNT_W-1:0] gble_role_lim(input gble_role_t r);
    case (r)
      GBLE_ROLE_IN: gble_role_lim = CNT_W'(MAX_IN);
      GBLE_ROLE_OUT: gble_role_lim = CNT_W'(MAX_OUT);
      GBLE_ROLE_RAIL_EN: gble_role_lim = CNT_W'(MAX_RAIL_EN);
      GBLE_ROLE_PWM: gble_role_lim = CNT_W'(MAX_PWM);
      GBLE_ROLE_MPWM: gble_role_lim = CNT_W'(MAX_MPWM);
      default: gble_role_lim = '0;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: gble_out_delay.sv
// gble_out_delay: assertion and deassertion delay of one logic output
`default_nettype none
module gble_out_delay (
  input wire logic core_clk_in, // device clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic raw_in, // undelayed logic result
  input wire logic dly_as_in, // delay on assertion
  input wire logic dly_ds_in, // delay on deassertion
  input wire logic ign_in, // ignore input during delay
  input wire logic [gble_pkg::DLY_W-1:0] as_ticks_in, // assertion delay
  input wire logic [gble_pkg::DLY_W-1:0] ds_ticks_in, // deassertion delay
  input wire logic tick_in, // delay time base
  output logic state_out // delayed logic state
);
  import gble_pkg::*;
  logic state_r, busy_r, tgt_r;
  logic [DLY_W:0] cnt_r;
  logic [DLY_W-1:0] eff_up, eff_dn, eff;
  logic chg;
  // in ignore mode a missing delay borrows the other one so no pulse is short
  assign eff_up = dly_as_in ? as_ticks_in : (ign_in & dly_ds_in) ? ds_ticks_in : '0;
  assign eff_dn = dly_ds_in ? ds_ticks_in : (ign_in & dly_as_in) ? as_ticks_in : '0;
  assign eff = raw_in ? eff_up : eff_dn;
  assign chg = !busy_r && (raw_in != state_r);
  assign state_out = state_r;
  // one extra tick is loaded since the first tick can arrive at once
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= 1'b0;
      busy_r <= 1'b0;
      tgt_r <= 1'b0;
      cnt_r <= '0;
    end else if (!busy_r) begin
      if (chg && eff == '0) begin
        state_r <= raw_in;
      end else if (chg) begin
        busy_r <= 1'b1;
        tgt_r <= raw_in;
        cnt_r <= {1'b0, eff} + (DLY_W + 1)'(1);
      end
    end else if (!ign_in && raw_in == state_r) begin
      busy_r <= 1'b0;
    end else if (tick_in) begin
      if (cnt_r == (DLY_W + 1)'(1)) begin
        state_r <= tgt_r;
        busy_r <= 1'b0;
      end
      cnt_r <= cnt_r - (DLY_W + 1)'(1);
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence reverted_s;
    busy_r && !ign_in && raw_in == state_r;
  endsequence
  sequence ign_wait_s;
    busy_r && ign_in && !(tick_in && cnt_r == (DLY_W + 1)'(1));
  endsequence
  glitch_filter_a: assert property (reverted_s |=> !busy_r && $stable(state_r))
    else $error("reverted change reached the output");
  ignore_commit_a: assert property (ign_wait_s |=> busy_r && $stable(state_r))
    else $error("pending change dropped in ignore mode");
  no_delay_a: assert property (chg && eff == '0 |=> state_r == $past(raw_in))
    else $error("undelayed change not taken at once");
endmodule
`default_nettype wire

// File: gble_gpio_top.sv
// gble_gpio_top: pin roles, input filters, output logic engine, register port
//
// Design decisions made here: the address map and strobed register access.
`default_nettype none
module gble_gpio_top #(
  parameter int DLY_TICK_CYC_P = gble_pkg::DLY_TICK_CYC // cycles per delay unit
) (
  input wire logic core_clk_in, // device clock, 10 MHz
  input wire logic sys_rst_in, // async reset, high
  input wire logic [gble_pkg::ADDR_W-1:0] reg_addr_in, // register word address
  input wire logic [gble_pkg::DATA_W-1:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [gble_pkg::DATA_W-1:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic [gble_pkg::NALL-1:0] pin_in, // pin levels
  output logic [gble_pkg::NALL-1:0] pin_drv_out, // pin output value
  output logic [gble_pkg::NALL-1:0] pin_oe_n_out, // pin enable, low drives
  input wire logic [gble_pkg::NLIVE*gble_pkg::NRAIL-1:0] rail_stat_in, // live rail flags
  input wire logic [gble_pkg::NRAIL-1:0] rail_vmon_in, // rail has voltage monitor
  input wire logic [gble_pkg::NRAIL-1:0] rail_en_in, // rail enables from sequencer
  input wire logic [gble_pkg::MAX_PWM-1:0] pwm_in, // pulse-width sources
  input wire logic [gble_pkg::MAX_MPWM-1:0] mrg_pwm_in, // margin pulse-width sources
  output logic [gble_pkg::NSLOT-1:0] general_output_out, // output logic states
  output logic [gble_pkg::NGPI-1:0] general_input_out // asserted inputs
);
  import gble_pkg::*;

  logic [PC_W-1:0] pin_cfg_r [NALL];
  logic [SC_W-1:0] slot_cfg_r [NSLOT];
  logic [DATA_W-1:0] term_r [2*NSLOT];
  logic [DATA_W-1:0] dly_r [NSLOT];
  logic [NALL-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [NLAT*NRAIL-1:0] lat_r, lat_set, lat_nxt;
  logic refused_r, ref_nxt;
  logic [NALL-1:0] asg_r; // pin has taken a role by a host write
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic [NSLOT-1:0] st, raw, gval, gval_r;
  logic [NGPI-1:0] gpi_v;
  logic lclr_in_v, lat_clr;
  logic [NALL-1:0] act, drv_nxt, oe_n_nxt;
  gble_role_t role_a [NALL];
  logic [SEL_W-1:0] sel_a [NALL];

  // register port decode
  logic pin_hit, slot_hit, pin_wr, slot_wr, cmd_wr;
  logic [PIDX_W-1:0] wr_pin;
  logic [ADDR_W-1:0] slot_off;
  logic [SEL_W-1:0] sidx;
  logic [1:0] sub;
  assign pin_hit = reg_addr_in < ADDR_W'(NALL);
  assign slot_off = reg_addr_in - A_SLOT_BASE;
  assign slot_hit = reg_addr_in >= A_SLOT_BASE && slot_off < ADDR_W'(4 * NSLOT);
  assign sidx = slot_off[SEL_W+1:2];
  assign sub = slot_off[1:0];
  assign wr_pin = reg_addr_in[PIDX_W-1:0];
  assign pin_wr = reg_wr_in && pin_hit;
  assign slot_wr = reg_wr_in && slot_hit;
  assign cmd_wr = reg_wr_in && reg_addr_in == A_STAT;

  // role write checks against counts and pin abilities
  gble_role_t new_role;
  logic [SEL_W-1:0] new_sel;
  logic [CNT_W-1:0] same_cnt, role_lim;
  logic lclr_taken, new_lclr, xpin_bad, refuse;
  assign new_role = gble_role_t'(reg_wdata_in[PC_ROLE_LSB +: ROLE_W]);
  assign new_sel = reg_wdata_in[PC_SEL_LSB +: SEL_W];
  assign new_lclr = reg_wdata_in[PC_LCLR];
  assign role_lim = gble_role_lim(new_role);
  always_comb begin
    same_cnt = '0;
    lclr_taken = 1'b0;
    for (int p = 0; p < NALL; p++) begin
      // pins still in their reset role hold no slot of the role budget
      if (p != int'(wr_pin) && asg_r[p] && role_a[p] == new_role) begin
        same_cnt = same_cnt + CNT_W'(1);
      end
      if (p != int'(wr_pin) && pin_cfg_r[p][PC_LCLR]) begin
        lclr_taken = 1'b1;
      end
    end
  end
  // the extra pins can never become logic outputs or rail enables
  assign xpin_bad = int'(wr_pin) >= NPIN &&
    (new_role == GBLE_ROLE_OUT || new_role == GBLE_ROLE_RAIL_EN);
  assign refuse = role_lim == '0 || same_cnt >= role_lim ||
    CNT_W'(new_sel) >= role_lim || xpin_bad ||
    (new_lclr && (new_role != GBLE_ROLE_IN || lclr_taken));
  assign ref_nxt = (pin_wr && refuse) || (refused_r && !(cmd_wr && reg_wdata_in[CMD_RCLR]));

  // configuration registers; a refused pin write leaves the old role in place
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int p = 0; p < NALL; p++) pin_cfg_r[p] <= PC_RST;
      refused_r <= 1'b0;
      asg_r <= '0;
    end else begin
      if (pin_wr && !refuse) pin_cfg_r[wr_pin] <= reg_wdata_in[PC_W-1:0];
      if (pin_wr && !refuse) asg_r[wr_pin] <= 1'b1;
      refused_r <= ref_nxt;
    end
  end

  // slot registers: mode word, two terms, delay pair
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int s = 0; s < NSLOT; s++) begin
        slot_cfg_r[s] <= '0;
        term_r[2*s] <= '0;
        term_r[2*s+1] <= '0;
        dly_r[s] <= '0;
      end
    end else if (slot_wr) begin
      case (sub)
        SUB_CFG: slot_cfg_r[sidx] <= reg_wdata_in[SC_W-1:0];
        SUB_T0: term_r[2*sidx] <= reg_wdata_in;
        SUB_T1: term_r[2*sidx+1] <= reg_wdata_in;
        SUB_DLY: dly_r[sidx] <= reg_wdata_in;
        default: dly_r[sidx] <= dly_r[sidx];
      endcase
    end
  end

  // read mux, answer registered one cycle after the strobe
  logic [DATA_W-1:0] slot_word, rd_word;
  assign slot_word = sub == SUB_CFG ? DATA_W'(slot_cfg_r[sidx]) :
    sub == SUB_T0 ? term_r[2*sidx] : sub == SUB_T1 ? term_r[2*sidx+1] : dly_r[sidx];
  assign rd_word = pin_hit ? DATA_W'(pin_cfg_r[wr_pin]) :
    slot_hit ? slot_word :
    reg_addr_in == A_STAT ? DATA_W'({|lat_r, refused_r}) :
    reg_addr_in == A_LVL ? DATA_W'(lvl_r) :
    reg_addr_in == A_STATE ? DATA_W'(gval_r) : '0;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) reg_rdata_out <= '0;
    else if (reg_rd_in) reg_rdata_out <= rd_word;
    else reg_rdata_out <= '0;
  end

  // pin synchroniser: a high level counts once the second and third stages agree; the level drops while they differ and holds once both are low
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & ~(s2_r ^ s3_r));
    end
  end

  // per-pin role fields, input assertion and output drive
  for (genvar p = 0; p < NALL; p++) begin : g_pin
    logic src, lv, drives, pp;
    assign role_a[p] = gble_role_t'(pin_cfg_r[p][PC_ROLE_LSB +: ROLE_W]);
    assign sel_a[p] = pin_cfg_r[p][PC_SEL_LSB +: SEL_W];
    assign pp = pin_cfg_r[p][PC_PP];
    assign act[p] = lvl_r[p] ~^ pin_cfg_r[p][PC_AH];
    assign src = role_a[p] == GBLE_ROLE_OUT ? gval[sel_a[p]] :
      role_a[p] == GBLE_ROLE_RAIL_EN ? rail_en_in[sel_a[p]] :
      role_a[p] == GBLE_ROLE_PWM ? pwm_in[sel_a[p]] :
      role_a[p] == GBLE_ROLE_MPWM ? mrg_pwm_in[sel_a[p]] : 1'b0;
    assign lv = src ~^ pin_cfg_r[p][PC_AH];
    assign drives = role_a[p] != GBLE_ROLE_IN;
    // open drain only ever pulls low; a high level is left to the pull-up
    assign drv_nxt[p] = drives & pp & lv;
    assign oe_n_nxt[p] = ~drives | (~pp & lv);
    in_undriven_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      role_a[p] == GBLE_ROLE_IN |=> pin_oe_n_out[p] && !pin_drv_out[p])
      else $error("input pin is driven");
    od_no_high_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !pp |=> !pin_drv_out[p])
      else $error("open-drain pin drives high");
    if (p >= NPIN) begin : g_xp
      xpin_role_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        role_a[p] != GBLE_ROLE_OUT && role_a[p] != GBLE_ROLE_RAIL_EN)
        else $error("extra pin holds a logic output role");
    end
  end

  // pin drive registers, undriven from reset until a role is set
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_drv_out <= '0;
      pin_oe_n_out <= '1;
    end else begin
      pin_drv_out <= drv_nxt;
      pin_oe_n_out <= oe_n_nxt;
    end
  end

  // input slots and the latch-clear source from asserted input pins
  always_comb begin
    gpi_v = '0;
    lclr_in_v = 1'b0;
    for (int p = 0; p < NALL; p++) begin
      // an unassigned pin is not yet an input slot, so it cannot assert one
      if (asg_r[p] && role_a[p] == GBLE_ROLE_IN) begin
        gpi_v[sel_a[p][2:0]] = gpi_v[sel_a[p][2:0]] | act[p];
        lclr_in_v = lclr_in_v | (act[p] & pin_cfg_r[p][PC_LCLR]);
      end
    end
  end

  // latched status copies; a new event wins over a clear in the same cycle
  assign lat_clr = (cmd_wr && reg_wdata_in[CMD_LCLR]) || lclr_in_v;
  assign lat_set = rail_stat_in[NLIVE*NRAIL-1:LAT_FIRST*NRAIL];
  assign lat_nxt = lat_set | (lat_r & ~{(NLAT*NRAIL){lat_clr}});
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) lat_r <= '0;
    else lat_r <= lat_nxt;
  end
  latch_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !lat_clr |=> (lat_r & $past(lat_r)) == $past(lat_r))
    else $error("latched flag dropped without a clear");
  latch_clr_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    lat_clr |=> lat_r == $past(lat_set))
    else $error("latch clear did not take effect");

  // delay time base shared by every slot
  assign tick = tick_cnt_r == TICK_W'(DLY_TICK_CYC_P - 1);
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) tick_cnt_r <= '0;
    else if (tick) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  // logic engine per slot: two AND terms, OR or state-machine choice, delay
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    logic [1:0] term;
    logic sm;
    for (genvar t = 0; t < 2; t++) begin : g_term
      logic [DATA_W-1:0] w;
      logic [TYPE_W-1:0] ty;
      logic [NRAIL-1:0] flg, rmask;
      assign w = term_r[2*s+t];
      assign ty = w[T_TYPE_LSB +: TYPE_W];
      assign flg = ty < TYPE_W'(NLIVE) ? rail_stat_in[int'(ty)*NRAIL +: NRAIL] :
        ty < TYPE_W'(LAT_CODE + NLAT) ? lat_r[(int'(ty) - LAT_CODE)*NRAIL +: NRAIL] : '0;
      // power-good of an unmonitored rail is left out of the term
      assign rmask = w[T_RAIL_LSB +: NRAIL] & (ty == TY_PG ? rail_vmon_in : '1);
      assign term[t] = w[T_EN] &
        &(~w[T_GPO_LSB +: NDEP] | gval[NDEP-1:0]) &
        &(~w[T_GPI_LSB +: NGPI] | gpi_v) &
        &(~rmask | flg);
    end
    assign sm = slot_cfg_r[s][SC_SM];
    assign raw[s] = sm ? (st[s] ? term[0] : term[1]) : |term;
    gble_out_delay u_dly (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .raw_in(raw[s]),
      .dly_as_in(slot_cfg_r[s][SC_DA]),
      .dly_ds_in(slot_cfg_r[s][SC_DD]),
      .ign_in(slot_cfg_r[s][SC_IGN]),
      .as_ticks_in(dly_r[s][DLY_W-1:0]),
      .ds_ticks_in(dly_r[s][2*DLY_W-1:DLY_W]),
      .tick_in(tick),
      .state_out(st[s])
    );
    // host command mode bypasses the engine entirely
    assign gval[s] = slot_cfg_r[s][SC_MAN] ? slot_cfg_r[s][SC_MVAL] : st[s];
    sm_path_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      sm && !slot_cfg_r[s][SC_MAN] |-> raw[s] == (gval[s] ? term[0] : term[1]))
      else $error("state-machine mode used the wrong term");
  end

  // logic states and inputs toward the sequencer and alarm logic
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gval_r <= '0;
      general_input_out <= '0;
    end else begin
      gval_r <= gval;
      general_input_out <= gpi_v;
    end
  end
  assign general_output_out = gval_r;

  role_limit_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    pin_wr && same_cnt >= role_lim |=> refused_r && $stable(pin_cfg_r[$past(wr_pin)]))
    else $error("role count limit not enforced");
endmodule
`default_nettype wire

// File: gble_ext_model.sv
// gble_ext_model: board-side pin wiring with pull-ups and external drivers
`default_nettype none
module gble_ext_model (
  input wire logic [22:0] pin_drv_in, // value the block drives
  input wire logic [22:0] pin_oe_n_in, // block enable, low drives
  input wire logic [22:0] ext_en_in, // external driver active
  input wire logic [22:0] ext_val_in, // external driver value
  output logic [22:0] pin_out // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines float up through the board pull-up, clash gives unknown
  always_comb begin
    for (int i = 0; i < 23; i++) begin
      if (!pin_oe_n_in[i] && ext_en_in[i]) begin
        pin_out[i] = 1'bx;
      end else if (!pin_oe_n_in[i]) begin
        pin_out[i] = pin_drv_in[i];
      end else begin
        pin_out[i] = ext_en_in[i] ? ext_val_in[i] : 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// tb_top: register-port bench for the output logic pin block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gble_pkg::*;
  localparam int TCK = 4; // short delay unit keeps the run brief
  logic clk, rst, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [NALL-1:0] lvl, drv, oe_n, ext_en, ext_val;
  logic [NLIVE*NRAIL-1:0] stat;
  logic [NSLOT-1:0] gout;
  logic [NGPI-1:0] gin;
  int mismatches, n_checks, cnt;
  gble_gpio_top #(.DLY_TICK_CYC_P(TCK)) u_dut (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .pin_in(lvl), .pin_drv_out(drv), .pin_oe_n_out(oe_n),
    .rail_stat_in(stat), .rail_vmon_in({NRAIL{1'b1}}), .rail_en_in({NRAIL{1'b0}}),
    .pwm_in({MAX_PWM{1'b0}}), .mrg_pwm_in({MAX_MPWM{1'b0}}),
    .general_output_out(gout), .general_input_out(gin));
  gble_ext_model u_ext (.pin_drv_in(drv), .pin_oe_n_in(oe_n), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pin_out(lvl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(nm, exp, rdata);
  endtask
  // bounded wait on one slot state; running out ends the run
  task automatic wait_gout(input int i, input logic v);
    int n;
    n = 0;
    while (gout[i] !== v && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 60) begin
      mismatches++;
      $display("unexpected timeout on slot state %0d", i);
      report_and_stop();
    end
  endtask
  task automatic pin_set(input int p, input logic v);
    @(posedge clk);
    ext_val[p] <= v;
  endtask
  // counts cycles in which slot 1 is high over a window
  task automatic count_high(input int len);
    cnt = 0;
    repeat (len) begin
      @(posedge clk);
      #1;
      if (gout[1] === 1'b1) cnt++;
    end
  endtask
  initial begin
    logic [39:0] bad [4] = '{{8'h15, 32'h1}, {8'h16, 32'h2}, {8'h05, 32'h100}, {8'h05, 32'h5}};
    rst = 1'b1;
    {wr, rd, addr, wdata, stat, ext_val} = '0;
    ext_en = 23'h000014; // inputs on pins 2 and 4
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("pin enables", {NALL{1'b1}}, oe_n);
    rd_reg(A_STATE, 32'h0, "slot states");
    // manual drive, push-pull and open-drain on the same slot
    wr_reg(8'h40, 32'h3);
    wr_reg(8'h00, 32'h19);
    wr_reg(8'h01, 32'h11);
    repeat (3) @(posedge clk);
    #1;
    check("manual levels", 32'h3, lvl[1:0]);
    check("manual enables", 32'h2, oe_n[1:0]);
    wr_reg(8'h40, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    check("manual low enables", 32'h0, oe_n[1:0]);
    // illegal role assignments are refused and flagged
    foreach (bad[k]) begin
      wr_reg(bad[k][39:32], bad[k][31:0]);
      rd_reg(A_STAT, 32'h1, "refused flag");
      wr_reg(A_STAT, 32'h2);
    end
    check("pin 21 undriven", 32'h1, oe_n[21]);
    // engine: slot 1 follows input slot 0 through term 0
    wr_reg(8'h02, 32'h10);
    wr_reg(8'h04, 32'h30);
    wr_reg(8'h03, 32'h39);
    wr_reg(8'h45, 32'h80000100);
    wr_reg(8'h44, 32'h0);
    pin_set(2, 1'b1);
    wait_gout(1, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check("engine pin", 32'h1, lvl[3]);
    check("input asserted", 32'h1, gin[0]);
    pin_set(2, 1'b0);
    wait_gout(1, 1'b0);
    wr_reg(8'h02, 32'h00);
    wait_gout(1, 1'b1);
    wr_reg(8'h02, 32'h10);
    wait_gout(1, 1'b0);
    // delays of two units: short pulse filtered, long one passes
    wr_reg(8'h47, 32'h00020002);
    wr_reg(8'h44, 32'h18);
    pin_set(2, 1'b1);
    repeat (2) @(posedge clk);
    pin_set(2, 1'b0);
    count_high(40);
    check("filtered pulse", 32'h0, cnt);
    pin_set(2, 1'b1);
    wait_gout(1, 1'b1);
    pin_set(2, 1'b0);
    wait_gout(1, 1'b0);
    // ignore mode commits a short pulse for at least the delay
    wr_reg(8'h44, 32'h38);
    pin_set(2, 1'b1);
    repeat (2) @(posedge clk);
    pin_set(2, 1'b0);
    wait_gout(1, 1'b1);
    count_high(2 * TCK);
    check("committed width", 2 * TCK, cnt);
    wait_gout(1, 1'b0);
    // state-machine mode: term 1 sets, term 0 holds
    wr_reg(8'h44, 32'h4);
    wr_reg(8'h46, 32'h80000200);
    pin_set(2, 1'b1);
    count_high(20);
    check("term 0 ignored when false", 32'h0, cnt);
    pin_set(4, 1'b1);
    wait_gout(1, 1'b1);
    pin_set(4, 1'b0);
    count_high(20);
    check("term 0 holds when true", 32'd20, cnt);
    pin_set(2, 1'b0);
    wait_gout(1, 1'b0);
    // latched overvoltage flag of rail 0 holds until cleared
    wr_reg(8'h44, 32'h0);
    wr_reg(8'h46, 32'h0);
    wr_reg(8'h45, 32'h80310000);
    @(posedge clk);
    stat[30] <= 1'b1;
    @(posedge clk);
    stat[30] <= 1'b0;
    wait_gout(1, 1'b1);
    count_high(20);
    check("latched hold", 32'd20, cnt);
    rd_reg(A_STAT, 32'h2, "latched flag");
    wr_reg(A_STAT, 32'h1);
    wait_gout(1, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
